// ===== logic/rspc_config.sv
// LINE_POSITIVE slave port configuration, address filter and node guard
// Operation
// - Slave: accept own frames, acknowledge legal parameter accesses
// - Switch address: first bank 4, second bank 1-4
// - Rotary code selects baud and character format
// - Defaults: address 1, 9600, 7-E-1
// - Switchless: address, baud from stored parameters
// - Millisecond node guard, zero disables it
// - Guard error clears the timeout to zero
// - Baud parameter accepts 9600, 19200, 38400 only
// - Format word: parity off, odd, 8 bits, 2 stop
`timescale 1ns/10ps
module rspc_config #(
  parameter int CYCLES_PER_MS = rspc_pkg::CYCLES_PER_MS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hasSwitches,
  input wire logic firstSwitchBank4,
  input wire logic [3:0] secondSwitchBank,
  input wire logic [3:0] rateFormatRotarySwitch,
  input wire logic frameValid,
  input wire logic [4:0] frameAddr,
  input wire logic paramWrEn,
  input wire logic paramRdEn,
  input wire logic [15:0] paramIndex,
  input wire logic [15:0] paramWrData,
  output logic [15:0] paramRdData,
  output logic paramAck,
  output logic paramErr,
  output logic frameAccept,
  output logic guardError,
  output logic configValid,
  output logic [4:0] activeAddr,
  output logic [15:0] activeBaud,
  output logic parityEn,
  output logic parityOdd,
  output logic dataBits8,
  output logic stopBits2
);
  import rspc_pkg::*;

  // ************************************************************
  // Switch synchronisers and strap capture
  // ************************************************************
  logic [8:0] swSync1, swSync2, swSync3, swStable;
  logic strapDone, useSwitches;
  wire [8:0] swPins = {rateFormatRotarySwitch, firstSwitchBank4,
                       secondSwitchBank};

  // A change counts only once the second and third stage agree;
  // the strap is static, so it is caught once after release
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {swSync1, swSync2, swSync3, swStable} <= 36'h000000000;
      strapDone <= 1'b0;
      useSwitches <= 1'b0;
    end else begin
      swSync1 <= swPins;
      swSync2 <= swSync1;
      swSync3 <= swSync2;
      if (swSync2 == swSync3) begin
        swStable <= swSync3;
      end
      if (!strapDone) begin
        strapDone <= 1'b1;
        useSwitches <= hasSwitches;
      end
    end
  end

  // ************************************************************
  // Stored parameters
  // ************************************************************
  logic [15:0] nodeGuardTimeout, serialBaudRate;
  logic [15:0] serialNodeAddress, serialCharFormat;

  wire selGuard = paramIndex == IDX_NODE_GUARD_TIMEOUT;
  wire selBaud = paramIndex == IDX_SERIAL_BAUD_RATE;
  wire selAddr = paramIndex == IDX_SERIAL_NODE_ADDRESS;
  wire selFmt = paramIndex == IDX_SERIAL_CHAR_FORMAT;
  wire selAny = selGuard | selBaud | selAddr | selFmt;
  wire baudLegal = paramWrData == BAUD_9600 ||
                   paramWrData == BAUD_19200 ||
                   paramWrData == BAUD_38400;
  wire addrLegal = paramWrData >= ADDR_MIN && paramWrData <= ADDR_MAX;
  wire fmtLegal = paramWrData <= FORMAT_MAX;
  wire guardLegal = paramWrData <= GUARD_MS_MAX;
  wire wrLegal = (selGuard & guardLegal) | (selBaud & baudLegal) |
                 (selAddr & addrLegal) | (selFmt & fmtLegal);
  wire wrOk = paramWrEn & wrLegal;
  wire guardHit;

  // A write and a read together is a write: no read data then
  wire [15:0] next_paramRdData =
    !paramRdEn || paramWrEn ? 16'h0000 :
    selGuard ? nodeGuardTimeout :
    selBaud ? serialBaudRate :
    selAddr ? serialNodeAddress :
    selFmt ? serialCharFormat : 16'h0000;
  wire next_paramAck = (paramWrEn & wrLegal) |
                       (!paramWrEn & paramRdEn & selAny);
  wire next_paramErr = (paramWrEn & !wrLegal) |
                       (!paramWrEn & paramRdEn & !selAny);

  // Guard error beats a same-cycle write, so no stale value stays armed
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      nodeGuardTimeout <= RST_NODE_GUARD_TIMEOUT;
      serialBaudRate <= RST_SERIAL_BAUD_RATE;
      serialNodeAddress <= RST_SERIAL_NODE_ADDRESS;
      serialCharFormat <= RST_SERIAL_CHAR_FORMAT;
    end else begin
      if (guardHit) begin
        nodeGuardTimeout <= 16'h0000;
      end else if (wrOk && selGuard) begin
        nodeGuardTimeout <= paramWrData;
      end
      if (wrOk && selBaud) begin
        serialBaudRate <= paramWrData;
      end
      if (wrOk && selAddr) begin
        serialNodeAddress <= paramWrData;
      end
      if (wrOk && selFmt) begin
        serialCharFormat <= paramWrData;
      end
    end
  end

  // ************************************************************
  // Active link configuration
  // ************************************************************
  wire [3:0] rotCode = swStable[8:5];
  wire [4:0] swAddr = swStable[4:0];
  wire rotValid = rotCode[1:0] != 2'b11;
  wire [15:0] rotBaud = rotCode[1:0] == 2'b00 ? BAUD_9600 :
                        rotCode[1:0] == 2'b01 ? BAUD_19200 :
                        BAUD_38400;

  wire [4:0] next_activeAddr = useSwitches ? swAddr :
                               serialNodeAddress[4:0];
  wire [15:0] next_activeBaud = useSwitches ? rotBaud :
                                serialBaudRate;
  wire next_configValid = !useSwitches || rotValid;
  wire next_parityEn = useSwitches ? !rotCode[2] :
                       !serialCharFormat[FMT_NO_PARITY];
  wire next_parityOdd = useSwitches ? 1'b0 :
                        serialCharFormat[FMT_ODD_PARITY];
  wire next_dataBits8 = useSwitches ? rotCode[3] :
                        serialCharFormat[FMT_EIGHT_BITS];
  wire next_stopBits2 = useSwitches ? 1'b0 :
                        serialCharFormat[FMT_TWO_STOP];

  // Foreign or misconfigured traffic never reaches the protocol
  wire next_frameAccept = frameValid && configValid &&
                          frameAddr == activeAddr;

  // ************************************************************
  // Node guard
  // ************************************************************
  localparam int MS_W = $clog2(CYCLES_PER_MS + 1);
  logic [MS_W-1:0] msCount;
  logic [15:0] guardMs;
  wire msTick = msCount == MS_W'(CYCLES_PER_MS - 1);
  wire guardRestart = frameAccept | (wrOk & selGuard);
  assign guardHit = nodeGuardTimeout != 16'h0000 && msTick &&
                    guardMs + 16'h0001 >= nodeGuardTimeout;

  // Elapsed time restarts on every accepted frame and legal timeout write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      msCount <= '0;
      guardMs <= 16'h0000;
    end else if (guardRestart || nodeGuardTimeout == 16'h0000) begin
      msCount <= '0;
      guardMs <= 16'h0000;
    end else if (msTick) begin
      msCount <= '0;
      guardMs <= guardMs + 16'h0001;
    end else begin
      msCount <= msCount + MS_W'(1);
    end
  end

  // ************************************************************
  // Output registers
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      paramRdData <= 16'h0000;
      {paramAck, paramErr, frameAccept, guardError} <= 4'h0;
      configValid <= 1'b1;
      activeAddr <= RST_SERIAL_NODE_ADDRESS[4:0];
      activeBaud <= RST_SERIAL_BAUD_RATE;
      parityEn <= 1'b1;
      {parityOdd, dataBits8, stopBits2} <= 3'h0;
    end else begin
      paramRdData <= next_paramRdData;
      paramAck <= next_paramAck;
      paramErr <= next_paramErr;
      frameAccept <= next_frameAccept;
      guardError <= guardHit;
      configValid <= next_configValid;
      activeAddr <= next_activeAddr;
      activeBaud <= next_activeBaud;
      parityEn <= next_parityEn;
      parityOdd <= next_parityOdd;
      dataBits8 <= next_dataBits8;
      stopBits2 <= next_stopBits2;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  property p_accept_own;
    @(posedge clk) disable iff (rst)
    frameValid && configValid && frameAddr == activeAddr |=> frameAccept;
  endproperty
  a_accept_own: assert property (p_accept_own)
    else $error("own frame not accepted");
  property p_ignore_foreign;
    @(posedge clk) disable iff (rst)
    frameValid && frameAddr != activeAddr |=> !frameAccept;
  endproperty
  a_ignore_foreign: assert property (p_ignore_foreign)
    else $error("foreign frame accepted");
  property p_switch_addr;
    @(posedge clk) disable iff (rst)
    strapDone && useSwitches |=> activeAddr == $past(swStable[4:0]);
  endproperty
  a_switch_addr: assert property (p_switch_addr)
    else $error("switch address not applied");
  property p_rotary;
    @(posedge clk) disable iff (rst)
    useSwitches && $stable(swStable) ##1 $stable(swStable) |->
      activeBaud == (swStable[6:5] == 2'b00 ? BAUD_9600 :
      swStable[6:5] == 2'b01 ? BAUD_19200 : BAUD_38400) &&
      dataBits8 == swStable[8] && parityEn == !swStable[7] &&
      configValid == (swStable[6:5] != 2'b11);
  endproperty
  a_rotary: assert property (p_rotary)
    else $error("rotary decode wrong");
  property p_defaults;
    @(posedge clk) disable iff (rst)
    !strapDone |-> activeAddr == 5'h01 && activeBaud == BAUD_9600 &&
      parityEn && !parityOdd && !dataBits8 && !stopBits2;
  endproperty
  a_defaults: assert property (p_defaults)
    else $error("reset defaults wrong");
  property p_stored;
    @(posedge clk) disable iff (rst)
    strapDone && !useSwitches |=>
      activeAddr == $past(serialNodeAddress[4:0]) &&
      activeBaud == $past(serialBaudRate);
  endproperty
  a_stored: assert property (p_stored)
    else $error("stored address or baud not applied");
  property p_guard_off;
    @(posedge clk) disable iff (rst)
    nodeGuardTimeout == 16'h0000 |=> !guardError;
  endproperty
  a_guard_off: assert property (p_guard_off)
    else $error("guard error while disabled");
  property p_guard_clear;
    @(posedge clk) disable iff (rst)
    guardError |-> nodeGuardTimeout == 16'h0000 ##1 !guardError;
  endproperty
  a_guard_clear: assert property (p_guard_clear)
    else $error("timeout not cleared after guard error");
  property p_baud_reject;
    @(posedge clk) disable iff (rst)
    paramWrEn && selBaud && !baudLegal |=>
      paramErr && !paramAck && $stable(serialBaudRate);
  endproperty
  a_baud_reject: assert property (p_baud_reject)
    else $error("illegal baud accepted");
  property p_format;
    @(posedge clk) disable iff (rst)
    strapDone && !useSwitches |=>
      parityOdd == $past(serialCharFormat[FMT_ODD_PARITY]) &&
      stopBits2 == $past(serialCharFormat[FMT_TWO_STOP]) &&
      parityEn == !$past(serialCharFormat[FMT_NO_PARITY]);
  endproperty
  a_format: assert property (p_format)
    else $error("format word decode wrong");
  c_guard_error: cover property (@(posedge clk) disable iff (rst) guardError);
  c_frame_accept: cover property (@(posedge clk) disable iff (rst)
    frameAccept);
  c_baud_write: cover property (@(posedge clk) disable iff (rst)
    paramWrEn && selBaud && baudLegal ##1 paramAck);
  c_rotary_bad: cover property (@(posedge clk) disable iff (rst)
    useSwitches && !configValid);

endmodule : rspc_config

// ===== logic/rspc_pkg.sv
// Constants shared by the LINE_POSITIVE slave port configuration block
package rspc_pkg;

  // ************************************************************
  // Parameter identifiers: index in the high byte, subindex low
  // ************************************************************
  localparam logic [15:0] IDX_NODE_GUARD_TIMEOUT = 16'h010b;
  localparam logic [15:0] IDX_SERIAL_BAUD_RATE = 16'h1601;
  localparam logic [15:0] IDX_SERIAL_NODE_ADDRESS = 16'h1602;
  localparam logic [15:0] IDX_SERIAL_CHAR_FORMAT = 16'h1603;

  // ************************************************************
  // Values after reset
  // ************************************************************
  localparam logic [15:0] RST_NODE_GUARD_TIMEOUT = 16'h0000;
  localparam logic [15:0] RST_SERIAL_BAUD_RATE = 16'h2580;
  localparam logic [15:0] RST_SERIAL_NODE_ADDRESS = 16'h0001;
  localparam logic [15:0] RST_SERIAL_CHAR_FORMAT = 16'h0000;

  // ************************************************************
  // Legal values and limits
  // ************************************************************
  localparam logic [15:0] BAUD_9600 = 16'h2580;
  localparam logic [15:0] BAUD_19200 = 16'h4b00;
  localparam logic [15:0] BAUD_38400 = 16'h9600;
  localparam logic [15:0] ADDR_MIN = 16'h0001;
  localparam logic [15:0] ADDR_MAX = 16'h001f;
  localparam logic [15:0] FORMAT_MAX = 16'h000f;
  localparam logic [15:0] GUARD_MS_MAX = 16'h2710;

  // ************************************************************
  // Character format word bit positions
  // ************************************************************
  localparam int FMT_NO_PARITY = 0;
  localparam int FMT_ODD_PARITY = 1;
  localparam int FMT_EIGHT_BITS = 2;
  localparam int FMT_TWO_STOP = 3;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_FREQ_KHZ = 250000;
  localparam int GUARD_UNIT_MS = 1;
  localparam int CYCLES_PER_MS = CLK_FREQ_KHZ * GUARD_UNIT_MS;
  localparam int SYNC_STAGES = 3;

endpackage : rspc_pkg

// ===== tb/rspc_master.sv
// Bus master model driving the parameter and frame ports of the node
`timescale 1ns/10ps
module rspc_master (
  input wire logic clk,
  input wire logic paramAck,
  input wire logic paramErr,
  input wire logic [15:0] paramRdData,
  input wire logic frameAccept,
  output logic frameValid,
  output logic [4:0] frameAddr,
  output logic paramWrEn,
  output logic paramRdEn,
  output logic [15:0] paramIndex,
  output logic [15:0] paramWrData
);
  initial begin
    frameValid = 1'b0;
    frameAddr = 5'h1e;
    paramWrEn = 1'b0;
    paramRdEn = 1'b0;
    paramIndex = 16'hffff;
    paramWrData = 16'hffff;
  end

  // ************************************************************
  // Transfers
  // ************************************************************
  // Released index, data and address lines show the inverse so a stale value never passes
  task automatic access(input logic wr, input logic [15:0] idx,
    input logic [15:0] data, output logic ack, output logic err,
    output logic [15:0] rd);
    @(posedge clk);
    paramWrEn <= wr;
    paramRdEn <= ~wr;
    paramIndex <= idx;
    paramWrData <= data;
    @(posedge clk);
    paramWrEn <= 1'b0;
    paramRdEn <= 1'b0;
    paramIndex <= ~idx;
    paramWrData <= ~data;
    #1;
    ack = paramAck;
    err = paramErr;
    rd = paramRdData;
  endtask : access

  // Only one node is spoken to, so default settings cannot collide
  task automatic frame(input logic [4:0] addr, output logic acc);
    @(posedge clk);
    frameValid <= 1'b1;
    frameAddr <= addr;
    @(posedge clk);
    frameValid <= 1'b0;
    frameAddr <= ~addr;
    #1;
    acc = frameAccept;
  endtask : frame
endmodule : rspc_master

// ===== tb/testbench.sv
// Self-checking testbench of the LINE_POSITIVE slave port configuration block
`timescale 1ns/10ps
module testbench;
  import rspc_pkg::*;
  localparam int CPM = 4;
  logic clk, rst, hasSwitches, firstSwitchBank4, acc;
  logic [3:0] secondSwitchBank, rateFormatRotarySwitch, code;
  logic frameValid, paramWrEn, paramRdEn, paramAck, paramErr, frameAccept;
  logic guardError, configValid, parityEn, parityOdd, dataBits8, stopBits2;
  logic [4:0] frameAddr, activeAddr;
  logic [15:0] paramIndex, paramWrData, paramRdData, activeBaud, v;
  logic [15:0] mReg [0:4];
  logic [15:0] idxTab [0:4];
  logic [31:0] corner [0:9];
  int seed, errTotal, checked, guardCount, i, k, n, r;

  rspc_config #(.CYCLES_PER_MS(CPM)) i_rspc_config (.clk(clk), .rst(rst),
    .hasSwitches(hasSwitches), .firstSwitchBank4(firstSwitchBank4),
    .secondSwitchBank(secondSwitchBank),
    .rateFormatRotarySwitch(rateFormatRotarySwitch),
    .frameValid(frameValid), .frameAddr(frameAddr), .paramWrEn(paramWrEn),
    .paramRdEn(paramRdEn), .paramIndex(paramIndex),
    .paramWrData(paramWrData), .paramRdData(paramRdData),
    .paramAck(paramAck), .paramErr(paramErr), .frameAccept(frameAccept),
    .guardError(guardError), .configValid(configValid),
    .activeAddr(activeAddr), .activeBaud(activeBaud), .parityEn(parityEn),
    .parityOdd(parityOdd), .dataBits8(dataBits8), .stopBits2(stopBits2));

  rspc_master i_rspc_master (.clk(clk), .paramAck(paramAck),
    .paramErr(paramErr), .paramRdData(paramRdData),
    .frameAccept(frameAccept), .frameValid(frameValid),
    .frameAddr(frameAddr), .paramWrEn(paramWrEn), .paramRdEn(paramRdEn),
    .paramIndex(paramIndex), .paramWrData(paramWrData));

  always #2 clk = ~clk;

  always @(posedge clk) begin
    if (guardError === 1'b1) begin
      guardCount++;
    end
  end

  // ************************************************************
  // Compare and expectation helpers
  // ************************************************************
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      errTotal++;
      $display("mismatch at %0t: word %h expected %h", $time, got, exp);
    end
  endtask : chk16

  task automatic chk1(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      errTotal++;
      $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask : chk1

  function automatic logic legal(input logic [15:0] idx, input logic [15:0] d);
    case (idx)
      16'h1601: return d == 16'h2580 || d == 16'h4b00 || d == 16'h9600;
      16'h1602: return d >= 16'h0001 && d <= 16'h001f;
      16'h1603: return d <= 16'h000f;
      16'h010b: return d <= 16'h2710;
      default: return 1'b0;
    endcase
  endfunction : legal

  function automatic int slot(input logic [15:0] idx);
    for (int j = 0; j < 4; j++) begin
      if (idxTab[j] == idx) begin
        return j;
      end
    end
    return 4;
  endfunction : slot

  // Invalid rotary codes leave the baud output at the highest rate
  function automatic logic [15:0] rotBaud(input logic [1:0] c);
    return c == 2'h0 ? 16'h2580 : (c == 2'h1 ? 16'h4b00 : 16'h9600);
  endfunction : rotBaud

  task automatic checkLink(input logic [4:0] a, input logic [15:0] b,
    input logic [3:0] f, input logic ok);
    chk16({11'h000, activeAddr}, {11'h000, a});
    chk16(activeBaud, b);
    chk1(parityEn, ~f[0]);
    chk1(parityOdd, f[1]);
    chk1(dataBits8, f[2]);
    chk1(stopBits2, f[3]);
    chk1(configValid, ok);
  endtask : checkLink

  task automatic readChk(input logic [15:0] idx);
    logic a, e;
    logic [15:0] d;
    i_rspc_master.access(1'b0, idx, 16'h0000, a, e, d);
    chk1(a, slot(idx) != 4);
    chk1(e, slot(idx) == 4);
    chk16(d, mReg[slot(idx)]);
  endtask : readChk

  task automatic setp(input logic [15:0] idx, input logic [15:0] d);
    logic a, e, ok;
    logic [15:0] q;
    ok = legal(idx, d);
    i_rspc_master.access(1'b1, idx, d, a, e, q);
    chk1(a, ok);
    chk1(e, ~ok);
    if (ok) begin
      mReg[slot(idx)] = d;
    end
    readChk(idx);
    checkLink(mReg[2][4:0], mReg[1], mReg[3][3:0], 1'b1);
  endtask : setp

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", checked, errTotal);
    if (errTotal == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  // ************************************************************
  // Sequence
  // ************************************************************
  initial begin
    repeat (20000) @(posedge clk);
    errTotal++;
    report_and_stop;
  end

  initial begin
    seed = 24;
    clk = 1'b0;
    rst = 1'b1;
    hasSwitches = 1'b0;
    firstSwitchBank4 = 1'b1;
    secondSwitchBank = 4'h6;
    rateFormatRotarySwitch = 4'h3;
    idxTab = '{16'h010b, 16'h1601, 16'h1602, 16'h1603, 16'h1604};
    mReg = '{16'h0000, 16'h2580, 16'h0001, 16'h0000, 16'h0000};
    corner = '{32'h16012581, 32'h16014b00, 32'h16019600, 32'h16010000,
      32'h16020000, 32'h16020020, 32'h1602001f, 32'h16030010,
      32'h1603000f, 32'h010b2711};
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    checkLink(5'h01, 16'h2580, 4'h0, 1'b1);
    i_rspc_master.frame(5'h01, acc);
    chk1(acc, 1'b1);
    for (i = 0; i < 5; i++) begin
      readChk(idxTab[i]);
    end
    for (i = 0; i < 10; i++) begin
      setp(corner[i][31:16], corner[i][15:0]);
    end
    for (i = 0; i < 40; i++) begin
      r = $random(seed);
      k = 1 + ($unsigned($random(seed)) % 4);
      v = r[1:0] == 2'h0 ? rotBaud(r[3:2]) :
        (r[1:0] == 2'h1 ? {10'h000, r[21:16]} : r[31:16]);
      setp(idxTab[k], v);
      i_rspc_master.frame(r[8:4], acc);
      chk1(acc, r[8:4] == mReg[2][4:0]);
    end
    setp(16'h010b, 16'h0002);
    n = 0;
    while (guardError !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    k = 2 * CPM - 2; // Two timeout cycles pass in setp's read-back
    chk16(n[15:0], k[15:0]);
    mReg[0] = 16'h0000;
    @(posedge clk);
    #1;
    chk1(guardError, 1'b0);
    readChk(16'h010b);
    setp(16'h010b, 16'h0003);
    k = guardCount;
    for (i = 0; i < 8; i++) begin
      i_rspc_master.frame(mReg[2][4:0], acc);
    end
    chk16(guardCount[15:0], k[15:0]);
    setp(16'h010b, 16'h0000);
    repeat (60) @(posedge clk);
    #1;
    chk16(guardCount[15:0], k[15:0]);
    rst <= 1'b1;
    hasSwitches <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      r = $random(seed);
      code = i[3:0];
      firstSwitchBank4 <= r[4];
      secondSwitchBank <= r[3:0];
      rateFormatRotarySwitch <= code;
      repeat (8) @(posedge clk);
      #1;
      checkLink(r[4:0], rotBaud(code[1:0]), {1'b0, code[3], 1'b0, code[2]},
        code[1:0] != 2'h3);
      i_rspc_master.frame(r[4:0], acc);
      chk1(acc, code[1:0] != 2'h3);
    end
    report_and_stop;
  end
endmodule : testbench
